// ---- gpb_top.sv ----
`timescale 1ns/1ps
module gpb_top
  import gpb_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  pin_in,
  output gpb_pad_type      pin_pad,
  input  wire logic        osc_pin_in,
  output logic             osc_pin_out,
  output logic             osc_pin_oe,
  output logic             irq_out_n,
  output logic             osc_active,
  output logic             fade_log_b
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Edge match for one pin against its two-bit field
  function automatic logic edge_hit(input logic [1:0] sense, input logic prev,
                                    input logic cur);
    edge_hit = (sense[0] && !prev && cur) || (sense[1] && prev && !cur);
  endfunction : edge_hit

  // Which of four fields differ between old and new register value
  function automatic logic [3:0] field_diff(input logic [7:0] a, input logic [7:0] b);
    logic [3:0] d;
    d = 4'h0;
    for (int k = 0; k < 4; k++)
      d[k] = (a[2*k +: 2] != b[2*k +: 2]);
    field_diff = d;
  endfunction : field_diff

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  od_reg;
  logic [7:0]  pol_reg;
  logic [7:0]  dir_reg;
  logic [7:0]  data_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  sense_hi_reg;
  logic [7:0]  sense_lo_reg;
  logic [7:0]  pend_reg;
  logic [7:0]  evt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  clk_reg;
  logic [7:0]  misc_reg;
  logic [7:0]  prev_reg;
  logic        prev_ok_reg;

  logic [7:0]  pin_val;
  logic [15:0] sense_all;
  logic [7:0]  edge_evt;
  logic [7:0]  sense_chg;
  logic [7:0]  evt_clr;
  logic [7:0]  pend_set;
  logic [7:0]  pend_clr;
  logic [7:0]  evt_next;
  logic [7:0]  pend_next;
  logic        rd_value;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] addr,
                                 input logic wr);
    wr_at = wr && (a == addr);
  endfunction : wr_at

  // Configuration registers; plain read/write storage except data_reg, whose offset reads back the pins
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      od_reg       <= RST_ZERO;
      pol_reg      <= RST_ZERO;
      dir_reg      <= RST_ONES;
      data_reg     <= RST_ONES;
      mask_reg     <= RST_ONES;
      sense_hi_reg <= RST_ZERO;
      sense_lo_reg <= RST_ZERO;
      shift_reg    <= RST_ZERO;
      clk_reg      <= RST_ZERO;
      misc_reg     <= RST_ZERO;
    end
    else
    begin
      if (wr_at(reg_addr, ADDR_OPEN_DRAIN, reg_wr)) od_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_POLARITY, reg_wr)) pol_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_DIRECTION, reg_wr)) dir_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_PIN_VALUE, reg_wr)) data_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_IRQ_MASK, reg_wr)) mask_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_EDGE_UPPER, reg_wr)) sense_hi_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_EDGE_LOWER, reg_wr)) sense_lo_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_SHIFT_MODE, reg_wr)) shift_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_CLOCK_MGMT, reg_wr)) clk_reg <= reg_wdata;
      if (wr_at(reg_addr, ADDR_MISC, reg_wr)) misc_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and event flags
  // ----------------------------------------------------------------
  // Pin value as software sees it; edges are taken on this, after inversion
  assign pin_val   = pin_in ^ pol_reg;
  assign sense_all = {sense_hi_reg, sense_lo_reg};
  assign rd_value  = reg_rd && (reg_addr == ADDR_PIN_VALUE);

  // Event and clear terms; a new edge always wins over a clear in the same cycle
  always_comb
  begin
    edge_evt = 8'h00;
    for (int i = 0; i < 8; i++)
      edge_evt[i] = prev_ok_reg && edge_hit(sense_all[2*i +: 2], prev_reg[i],
                                            pin_val[i]);
    sense_chg = 8'h00;
    if (wr_at(reg_addr, ADDR_EDGE_UPPER, reg_wr))
      sense_chg[7:4] = field_diff(sense_hi_reg, reg_wdata);
    if (wr_at(reg_addr, ADDR_EDGE_LOWER, reg_wr))
      sense_chg[3:0] = field_diff(sense_lo_reg, reg_wdata);
    evt_clr = sense_chg;
    if (wr_at(reg_addr, ADDR_IRQ_PEND, reg_wr))
      evt_clr = evt_clr | reg_wdata;
    if (wr_at(reg_addr, ADDR_EDGE_EVENT, reg_wr))
      evt_clr = evt_clr | reg_wdata;
    pend_clr = evt_clr;
    if (rd_value && !misc_reg[MISC_AUTOCLR])
      pend_clr = RST_ONES;
    pend_set  = edge_evt & ~mask_reg & dir_reg;
    evt_next  = (evt_reg & ~evt_clr) | edge_evt;
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  // Previous pin value; first cycle after reset compares nothing
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      prev_reg    <= RST_ZERO;
      prev_ok_reg <= 1'b0;
    end
    else
    begin
      prev_reg    <= pin_val;
      prev_ok_reg <= 1'b1;
    end
  end

  // Sticky flags and the interrupt line, kept in step with the pending bits
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      evt_reg   <= RST_ZERO;
      pend_reg  <= RST_ZERO;
      irq_out_n <= 1'b1;
    end
    else
    begin
      evt_reg   <= evt_next;
      pend_reg  <= pend_next;
      irq_out_n <= ~(|pend_next);
    end
  end

  // ----------------------------------------------------------------
  // Pad drive with level shifter override
  // ----------------------------------------------------------------
  logic [7:0]  pad_lvl_next;
  logic [7:0]  pad_en_next;

  // Level and enable per pin; a shifter pair overrides the direction bit.
  // Looping over pairs keeps every partner index inside the pin bus.
  always_comb
  begin
    pad_lvl_next = 8'h00;
    pad_en_next  = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      pad_en_next[i]  = !dir_reg[i];
      pad_lvl_next[i] = data_reg[i] ^ pol_reg[i];
    end
    for (int p = 0; p < 4; p++)
    begin
      if (shift_reg[2*p +: 2] == SHIFT_A2B)
      begin
        pad_en_next[p + 4]  = 1'b1;
        pad_lvl_next[p + 4] = pin_in[p];
      end
      else if (shift_reg[2*p +: 2] == SHIFT_B2A)
      begin
        pad_en_next[p]  = 1'b1;
        pad_lvl_next[p] = pin_in[p + 4];
      end
    end
    pad_en_next = pad_en_next & (~od_reg | ~pad_lvl_next);
  end

  // Pad bundle straight from flops so the pins never glitch
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pin_pad <= '{drive: RST_ZERO, enable: RST_ZERO};
    else
      pin_pad <= '{drive: pad_lvl_next, enable: pad_en_next};
  end

  // ----------------------------------------------------------------
  // Clock management
  // ----------------------------------------------------------------
  logic [1:0]  osc_src;
  logic        osc_dir;
  logic [3:0]  osc_div;
  logic [4:0]  int_cnt_reg;
  logic        int_lvl_reg;
  logic        ext_sync1_reg;
  logic        ext_sync2_reg;
  logic        osc_lvl_reg;
  logic        osc_prev_reg;
  logic [12:0] div_cnt_reg;
  logic        osc_lvl_next;

  assign osc_src = clk_reg[CLK_SRC_HI:CLK_SRC_LO];
  assign osc_dir = clk_reg[CLK_PIN_DIR];
  assign osc_div = clk_reg[3:0];

  // Selected oscillator level; off and reserved codes give a still clock
  always_comb
  begin
    osc_lvl_next = 1'b0;
    if (osc_src == SRC_INT)
      osc_lvl_next = int_lvl_reg;
    else if (osc_src == SRC_EXT && !osc_dir)
      osc_lvl_next = ext_sync2_reg;
  end

  // Internal oscillator; runs only while selected to save toggling
  always_ff @(posedge mclk)
  begin
    if (!reset_n || osc_src != SRC_INT)
    begin
      int_cnt_reg <= 5'h00;
      int_lvl_reg <= 1'b0;
    end
    else if (int_cnt_reg == INT_HALF_LAST)
    begin
      int_cnt_reg <= 5'h00;
      int_lvl_reg <= !int_lvl_reg;
    end
    else
      int_cnt_reg <= int_cnt_reg + 5'h01;
  end

  // External clock synchroniser and divider chain on oscillator rises
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      osc_lvl_reg   <= 1'b0;
      osc_prev_reg  <= 1'b0;
      div_cnt_reg   <= 13'h0000;
    end
    else
    begin
      ext_sync1_reg <= osc_pin_in;
      ext_sync2_reg <= ext_sync1_reg;
      osc_lvl_reg   <= osc_lvl_next;
      osc_prev_reg  <= osc_lvl_reg;
      if (osc_lvl_reg && !osc_prev_reg)
        div_cnt_reg <= div_cnt_reg + 13'h0001;
    end
  end

  // Oscillator pin output; divide by 2^(n-1) means counter bit n-2
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      osc_pin_out <= 1'b0;
      osc_pin_oe  <= 1'b0;
      osc_active  <= 1'b0;
      fade_log_b  <= 1'b0;
    end
    else
    begin
      osc_pin_oe <= osc_dir;
      osc_active <= (osc_src == SRC_EXT) || (osc_src == SRC_INT);
      fade_log_b <= misc_reg[MISC_FADE_LOG];
      if (osc_div == DIV_LOW)
        osc_pin_out <= 1'b0;
      else if (osc_div == DIV_HIGH)
        osc_pin_out <= 1'b1;
      else if (osc_div == DIV_FULL)
        osc_pin_out <= osc_lvl_reg;
      else
        osc_pin_out <= div_cnt_reg[4'(osc_div - 4'h2)];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data is captured on the strobe; unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      reg_rdata <= RST_ZERO;
    else if (reg_rd)
      case (reg_addr)
        ADDR_OPEN_DRAIN: reg_rdata <= od_reg;
        ADDR_POLARITY:   reg_rdata <= pol_reg;
        ADDR_DIRECTION:  reg_rdata <= dir_reg;
        ADDR_PIN_VALUE:  reg_rdata <= pin_val;
        ADDR_IRQ_MASK:   reg_rdata <= mask_reg;
        ADDR_EDGE_UPPER: reg_rdata <= sense_hi_reg;
        ADDR_EDGE_LOWER: reg_rdata <= sense_lo_reg;
        ADDR_IRQ_PEND:   reg_rdata <= pend_reg;
        ADDR_EDGE_EVENT: reg_rdata <= evt_reg;
        ADDR_SHIFT_MODE: reg_rdata <= shift_reg;
        ADDR_CLOCK_MGMT: reg_rdata <= clk_reg;
        ADDR_MISC:       reg_rdata <= misc_reg;
        default:         reg_rdata <= RST_ZERO;
      endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_OD_FLOAT: assert property (
    ##1 ((pin_pad.enable & pin_pad.drive & $past(od_reg)) == 8'h00))
    else $error("open-drain pin driven high");
  AST_RESET_DIR: assert property (
    $rose(reset_n) |-> (dir_reg == 8'hFF) && (data_reg == 8'hFF) && (mask_reg == 8'hFF))
    else $error("direction, data or mask reset value wrong");
  AST_READ_PINS: assert property (
    (reg_rd && reg_addr == ADDR_PIN_VALUE) |=> reg_rdata == $past(pin_val))
    else $error("pin value read does not show pins");
  AST_MASK_BLOCK: assert property (
    ##1 ((pend_reg & ~$past(pend_reg) & $past(mask_reg)) == 8'h00))
    else $error("masked pin raised pending bit");
  AST_EVT_SET: assert property (
    (edge_evt != 8'h00) |=> ((evt_reg & $past(edge_evt)) == $past(edge_evt)))
    else $error("edge did not set event flag");
  AST_PEND_W1C: assert property (
    (wr_at(reg_addr, ADDR_IRQ_PEND, reg_wr) && edge_evt == 8'h00)
      |=> ((pend_reg | evt_reg) & $past(reg_wdata)) == 8'h00)
    else $error("pending write-one did not clear");
  AST_IRQ_LEVEL: assert property (
    ##1 (irq_out_n == ($past(pend_next) == 8'h00)) && (irq_out_n == (pend_reg == 8'h00)))
    else $error("interrupt line disagrees with pending bits");
  AST_AUTOCLR: assert property (
    (rd_value && !misc_reg[MISC_AUTOCLR] && pend_set == 8'h00) |=> pend_reg == 8'h00 ##1 1'b1)
    else $error("pin value read did not clear pending");
  AST_OSC_LOW: assert property (
    (osc_div == DIV_LOW) |=> !osc_pin_out)
    else $error("oscillator pin not held low");
  AST_SHIFT_A2B: assert property (
    (shift_reg[1:0] == SHIFT_A2B) |=> pin_pad.drive[4] == $past(pin_in[0]))
    else $error("upper pin does not follow lower pin");
  AST_SENSE_CLR: assert property (
    (sense_chg != 8'h00 && edge_evt == 8'h00)
      |=> ((pend_reg | evt_reg) & $past(sense_chg)) == 8'h00)
    else $error("edge field change did not clear flags");

  COV_IRQ: cover property ($fell(irq_out_n));
  COV_CLEAR: cover property ((pend_reg != 8'h00) ##[1:20] (pend_reg == 8'h00));
  COV_OSC: cover property ($rose(osc_pin_out) ##[1:200] $rose(osc_pin_out));
  COV_SHIFT: cover property ((shift_reg[1:0] == SHIFT_A2B) ##1 pin_pad.enable[4]);

endmodule : gpb_top

// ---- gpb_pkg.sv ----
package gpb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPEN_DRAIN = 8'h05;
  localparam logic [7:0] ADDR_POLARITY   = 8'h06;
  localparam logic [7:0] ADDR_DIRECTION  = 8'h07;
  localparam logic [7:0] ADDR_PIN_VALUE  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h09;
  localparam logic [7:0] ADDR_EDGE_UPPER = 8'h0A;
  localparam logic [7:0] ADDR_EDGE_LOWER = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_PEND   = 8'h0C;
  localparam logic [7:0] ADDR_EDGE_EVENT = 8'h0D;
  localparam logic [7:0] ADDR_SHIFT_MODE = 8'h0E;
  localparam logic [7:0] ADDR_CLOCK_MGMT = 8'h0F;
  localparam logic [7:0] ADDR_MISC       = 8'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int         CLK_SRC_HI     = 6;
  localparam int         CLK_SRC_LO     = 5;
  localparam int         CLK_PIN_DIR    = 4;
  localparam int         MISC_FADE_LOG  = 7;
  localparam int         MISC_AUTOCLR   = 0;
  localparam logic [1:0] SRC_OFF        = 2'h0;
  localparam logic [1:0] SRC_EXT        = 2'h1;
  localparam logic [1:0] SRC_INT        = 2'h2;
  localparam logic [3:0] DIV_LOW        = 4'h0;
  localparam logic [3:0] DIV_FULL       = 4'h1;
  localparam logic [3:0] DIV_HIGH       = 4'hF;
  localparam logic [1:0] EDGE_RISE      = 2'h1;
  localparam logic [1:0] EDGE_FALL      = 2'h2;
  localparam logic [1:0] SHIFT_A2B      = 2'h1;
  localparam logic [1:0] SHIFT_B2A      = 2'h2;

  // ----------------------------------------------------------------
  // Timing: internal oscillator made from the core clock
  // ----------------------------------------------------------------
  localparam int         CORE_CLK_HZ    = 32'h0262_5A00;
  localparam int         INT_OSC_HZ     = 32'h001E_8480;
  localparam int         INT_OSC_HALF   = CORE_CLK_HZ / (2 * INT_OSC_HZ);
  localparam logic [4:0] INT_HALF_LAST  = 5'(INT_OSC_HALF - 1);

  // Pad drive bundle: level and enable per pin
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] enable;
  } gpb_pad_type;

endpackage : gpb_pkg

// ---- gpb_pin_model.sv ----
`timescale 1ns/1ps
module gpb_pin_model
  import gpb_pkg::*;
(
  input  wire logic [7:0]  ext_drive,
  input  wire logic [7:0]  ext_en,
  input  wire logic        ext_osc,
  input  wire gpb_pad_type pin_pad,
  input  wire logic        osc_pin_out,
  input  wire logic        osc_pin_oe,
  output logic      [7:0]  pin_in,
  output logic             osc_pin_in
);

  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // Device drive wins, then the outside driver, else the board pull-up;
  // contention is not flagged, so scenarios keep the two apart
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_pad.enable[i])
        pin_in[i] = pin_pad.drive[i];
      else if (ext_en[i])
        pin_in[i] = ext_drive[i];
      else
        pin_in[i] = 1'b1;
    end
  end

  // Oscillator pin reads back its own drive when it is an output
  assign osc_pin_in = osc_pin_oe ? osc_pin_out : ext_osc;

endmodule : gpb_pin_model

// ---- tb_gpio_bank_config_irq_clock.sv ----
`timescale 1ns/1ps
module tb_gpio_bank_config_irq_clock
  import gpb_pkg::*;
;
  logic        mclk, reset_n, reg_wr, reg_rd, ext_osc;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ext_drive, ext_en, pin_in;
  gpb_pad_type pin_pad;
  logic        osc_pin_in, osc_pin_out, osc_pin_oe, irq_out_n, osc_active, fade_log_b;
  int          miscompares, samples_checked, a, b;
  logic [7:0]  rw_addr [8] = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h10};
  logic [7:0]  rw_rst  [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  gpb_top dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_pad(pin_pad), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .osc_pin_oe(osc_pin_oe), .irq_out_n(irq_out_n), .osc_active(osc_active),
    .fade_log_b(fade_log_b));

  gpb_pin_model pads (.ext_drive(ext_drive), .ext_en(ext_en), .ext_osc(ext_osc),
    .pin_pad(pin_pad), .osc_pin_out(osc_pin_out), .osc_pin_oe(osc_pin_oe),
    .pin_in(pin_in), .osc_pin_in(osc_pin_in));

  // ----------------------------------------------------------------
  // Clock, 25 ns period
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Strobes drop a full cycle later, so calls never collide in one step
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    chk(what, 16'(reg_rdata), 16'(exp));
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  task automatic setx(input logic [7:0] en, input logic [7:0] lvl);
    @(negedge mclk);
    ext_en    = en;
    ext_drive = lvl;
    idle(3);
  endtask : setx

  // Bounded wait for a level on the clock output, counting cycles
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (osc_pin_out !== v && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_lvl

  // ----------------------------------------------------------------
  // Watchdog: whole sequence needs a few hundred cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    ext_drive = 8'h00; ext_en = 8'h00; ext_osc = 1'b0;
    miscompares = 0; samples_checked = 0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    chk("irq idle", 16'(irq_out_n), 16'h0001);
    chk("pad enable", 16'(pin_pad.enable), 16'h0000);
    // Reset values, unmapped offsets and read back of every RW register except clock management at 0F
    for (int i = 0; i < 8; i++)
      rdchk("reset value", rw_addr[i], rw_rst[i]);
    rdchk("pin value reset", 8'h08, 8'hFF);
    rdchk("pending reset", 8'h0C, 8'h00);
    rdchk("events reset", 8'h0D, 8'h00);
    rdchk("clock reset", 8'h0F, 8'h00);
    rdchk("unmapped", 8'h11, 8'h00);
    rdchk("unmapped", 8'h04, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(rw_addr[i], 8'hA5);
      rdchk("rw pattern", rw_addr[i], 8'hA5);
      wr(rw_addr[i], rw_rst[i]);
    end
    // Outputs, push-pull versus open drain, polarity
    setx(8'h0F, 8'h05);
    wr(8'h07, 8'h0F);
    wr(8'h08, 8'h3C);
    idle(2);
    chk("push pull enable", 16'(pin_pad.enable), 16'h00F0);
    chk("drive level", 16'(pin_pad.drive[7:4]), 16'h0003);
    wr(8'h05, 8'hF0);
    idle(2);
    chk("open drain enable", 16'(pin_pad.enable), 16'h00C0);
    chk("open drain low", 16'(pin_pad.drive[7:6]), 16'h0000);
    rdchk("pin levels", 8'h08, 8'h35);
    wr(8'h06, 8'hFF);
    idle(2);
    chk("inverted enable", 16'(pin_pad.enable), 16'h0030);
    rdchk("inverted levels", 8'h08, 8'h3A);
    wr(8'h06, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h07, 8'hFF);
    // Edge codes per pin: 00, 01, 10, 11 from low pin up in each nibble
    setx(8'hFF, 8'h00);
    wr(8'h0B, 8'hE4);
    wr(8'h0A, 8'hE4);
    wr(8'h09, 8'hF0);
    setx(8'hFF, 8'hFF);
    chk("irq asserted", 16'(irq_out_n), 16'h0000);
    rdchk("rise events", 8'h0D, 8'hAA);
    rdchk("rise pending", 8'h0C, 8'h0A);
    wr(8'h0C, 8'h02);
    rdchk("pending w1c", 8'h0C, 8'h08);
    rdchk("events via pending", 8'h0D, 8'hA8);
    wr(8'h0D, 8'h08);
    rdchk("pending via events", 8'h0C, 8'h00);
    rdchk("events w1c", 8'h0D, 8'hA0);
    chk("irq released", 16'(irq_out_n), 16'h0001);
    setx(8'hFF, 8'h00);
    rdchk("fall events", 8'h0D, 8'hEC);
    rdchk("fall pending", 8'h0C, 8'h0C);
    wr(8'h0C, 8'h00);
    rdchk("write zero keeps", 8'h0C, 8'h0C);
    rdchk("pin value read", 8'h08, 8'h00);
    rdchk("autoclear pending", 8'h0C, 8'h00);
    rdchk("autoclear keeps events", 8'h0D, 8'hEC);
    wr(8'h0A, 8'h00);
    rdchk("edge change clears", 8'h0D, 8'h0C);
    wr(8'h10, 8'h01);
    setx(8'hFF, 8'hFF);
    rdchk("pin value read", 8'h08, 8'hFF);
    rdchk("no autoclear", 8'h0C, 8'h0A);
    wr(8'h0D, 8'hFF);
    rdchk("all cleared", 8'h0C, 8'h00);
    chk("irq released", 16'(irq_out_n), 16'h0001);
    wr(8'h10, 8'h00);
    wr(8'h09, 8'hFF);
    wr(8'h0B, 8'h00);
    // Level shift: pair 0 code 01, pair 1 code 10, pair 2 off, pair 3 reserved
    wr(8'h0E, 8'hC9);
    for (int v = 0; v < 2; v++)
    begin
      setx(8'h21, {2'b00, ~1'(v), 4'h0, 1'(v)});
      chk("shift enable", 16'(pin_pad.enable), 16'h0012);
      chk("shift drive", 16'({pin_pad.drive[4], pin_pad.drive[1]}), 16'({1'(v), ~1'(v)}));
    end
    wr(8'h0E, 8'h00);
    // Oscillator source codes, pin direction, fixed levels, divider
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h0F, {1'b0, 2'(s), 5'h00});
      idle(2);
      chk("osc active", 16'(osc_active), 16'(s == 1 || s == 2));
    end
    wr(8'h0F, 8'h10);
    idle(2);
    chk("osc pin output", 16'(osc_pin_oe), 16'h0001);
    chk("fixed low", 16'(osc_pin_out), 16'h0000);
    wr(8'h0F, 8'h1F);
    idle(2);
    chk("fixed high", 16'(osc_pin_out), 16'h0001);
    wr(8'h0F, 8'h0F);
    idle(2);
    chk("osc pin input", 16'(osc_pin_oe), 16'h0000);
    // External source, pin as input, undivided: output follows the pin
    wr(8'h0F, 8'h21);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge mclk);
      ext_osc = ~ext_osc;
      idle(5);
      chk("external clock", 16'(osc_pin_out), 16'(ext_osc));
    end
    for (int n = 1; n < 4; n++)
    begin
      wr(8'h0F, 8'h50 | 8'(n));
      idle(2);
      wait_lvl(1'b0, a);
      wait_lvl(1'b1, a);
      wait_lvl(1'b0, a);
      wait_lvl(1'b1, b);
      chk("divided period", 16'(a + b), 16'((2 * INT_OSC_HALF) << (n - 1)));
    end
    wr(8'h10, 8'h80);
    idle(2);
    chk("fade log", 16'(fade_log_b), 16'h0001);
    wr(8'h10, 8'h00);
    idle(2);
    chk("fade linear", 16'(fade_log_b), 16'h0000);
    print_verdict();
  end

endmodule : tb_gpio_bank_config_irq_clock
